// ===== hw/spctl_top.sv
// Operation
// - bit 7 clear: boot-mode pins steer program fetch; set: they are ignored
// - reads of bits 6:5 return the live boot-mode pin levels
// - writes to bits 6:5 are discarded; software writes zeros there
// - mode 00: slave port off, port A is an eight-bit input
// - mode 01: slave port off, port A drives as eight-bit output
// - mode 10: slave port on, host reaches it through port A
// - mode 11: external I/O bus, port A data, port B 7:2 address
// - priority 00: no slave port interrupt request is raised
// - priority 01, 10, 11 raise slave interrupts at level 1, 2, 3
module spctl_top
	import spctl_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk_in,
	input  wire logic       resetn_in,
	input  wire logic       clk_en_in,
	// register port
	input  wire logic [7:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic [7:0]      rdata_out,
	// pins
	input  wire logic [1:0] boot_mode_pins_in,
	input  wire logic       port_e_bit_seven_in,
	input  wire logic       port_b_bit_six_in,
	input  wire logic       slave_irq_req_in,
	// controls
	output logic            fetch_by_pins_out,
	output logic            slave_chip_select_n_out,
	output logic            slave_port_en_out,
	output logic            io_bus_en_out,
	output logic            pa_drive_out,
	output logic            pb_addr_en_out,
	output logic [1:0]      irq_prio_out,
	// interrupt
	output logic            irq_out
);
	spctl_cfg_s  cfg_ff;
	spctl_port_s port_s;
	logic [1:0]  irq_stat_ff;
	logic [1:0]  irq_mask_ff;
	logic [7:0]  nxt_rdata;
	logic [7:0]  rdata_ff;
	logic        slave_req_ff;
	logic [1:0]  irq_set;
	logic        wr_ctrl;
	logic        wr_stat;

	assign wr_ctrl = clk_en_in && wr_in && addr_in == SPCTL_ADDR_CTRL;
	assign wr_stat = clk_en_in && wr_in && addr_in == SPCTL_ADDR_IRQ_STAT;

	// bits 6:5 are never stored, so a stray write cannot reach them
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			cfg_ff <= spctl_cfg_s'({SPCTL_CTRL_RST[SPCTL_BIT_FETCH_IGN],
			                        SPCTL_CTRL_RST[SPCTL_BIT_CS_SEL:SPCTL_BIT_PRIO_LO]});
		end else if (wr_ctrl) begin
			cfg_ff.fetch_ignore <= wdata_in[SPCTL_BIT_FETCH_IGN];
			cfg_ff.cs_from_pb6  <= wdata_in[SPCTL_BIT_CS_SEL];
			cfg_ff.pmode        <= spctl_pmode_e'(wdata_in[SPCTL_BIT_PMODE_HI:SPCTL_BIT_PMODE_LO]);
			cfg_ff.prio         <= wdata_in[SPCTL_BIT_PRIO_HI:SPCTL_BIT_PRIO_LO];
		end
	end

	assign fetch_by_pins_out = !cfg_ff.fetch_ignore;

	spctl_decode u_decode (
		.cfg_in                  (cfg_ff),
		.port_e_bit_seven_in     (port_e_bit_seven_in),
		.port_b_bit_six_in       (port_b_bit_six_in),
		.slave_irq_req_in        (slave_irq_req_in),
		.port_out                (port_s),
		.slave_chip_select_n_out (slave_chip_select_n_out),
		.irq_prio_out            (irq_prio_out)
	);

	assign slave_port_en_out = port_s.slave_port_en;
	assign io_bus_en_out     = port_s.io_bus_en;
	assign pa_drive_out      = port_s.pa_drive;
	assign pb_addr_en_out    = port_s.pb_addr_en;

	// events: rising slave request while enabled, and any port mode change
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			slave_req_ff <= 1'b0;
		end else if (clk_en_in) begin
			slave_req_ff <= slave_irq_req_in;
		end
	end

	always_comb begin
		irq_set = 2'h0;
		irq_set[SPCTL_IRQ_SLAVE] = slave_irq_req_in && !slave_req_ff && (irq_prio_out != 2'h0);
		irq_set[SPCTL_IRQ_PMCHG] = wr_ctrl &&
			(wdata_in[SPCTL_BIT_PMODE_HI:SPCTL_BIT_PMODE_LO] != cfg_ff.pmode);
	end

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			irq_stat_ff <= SPCTL_IRQ_RST;
		end else if (clk_en_in) begin
			irq_stat_ff <= (irq_stat_ff & ~(wr_stat ? wdata_in[1:0] : 2'h0)) | irq_set;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			irq_mask_ff <= SPCTL_IRQ_RST;
		end else if (clk_en_in && wr_in && addr_in == SPCTL_ADDR_IRQ_MASK) begin
			irq_mask_ff <= wdata_in[1:0];
		end
	end

	assign irq_out = |(irq_stat_ff & irq_mask_ff);

	always_comb begin
		nxt_rdata = 8'h00;
		case (addr_in)
			SPCTL_ADDR_CTRL: begin
				nxt_rdata = {cfg_ff.fetch_ignore, boot_mode_pins_in, cfg_ff.cs_from_pb6,
				             cfg_ff.pmode, cfg_ff.prio};
			end
			SPCTL_ADDR_IRQ_STAT: begin
				nxt_rdata = {6'h00, irq_stat_ff};
			end
			SPCTL_ADDR_IRQ_MASK: begin
				nxt_rdata = {6'h00, irq_mask_ff};
			end
			default: begin
				nxt_rdata = 8'h00;
			end
		endcase
	end

	// data stands after a taken read strobe until the next clock-enabled edge clears it
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			rdata_ff <= 8'h00;
		end else if (clk_en_in) begin
			rdata_ff <= rd_in ? nxt_rdata : 8'h00;
		end
	end

	assign rdata_out = rdata_ff;

	property p_fetch;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		wr_ctrl |=> fetch_by_pins_out == !$past(wdata_in[7]);
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch control wrong");

	property p_pins_read;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		(clk_en_in && rd_in && addr_in == SPCTL_ADDR_CTRL) |=>
			rdata_out[6:5] == $past(boot_mode_pins_in);
	endproperty
	a_pins_read: assert property (p_pins_read) else $error("pin readback wrong");

	// register accesses and the slave event as the port takes them; the master may leave idle cycles between
	sequence s_ctrl_write;
		wr_ctrl;
	endsequence

	sequence s_ctrl_read;
		clk_en_in && rd_in && addr_in == SPCTL_ADDR_CTRL;
	endsequence

	sequence s_slave_event;
		clk_en_in && slave_irq_req_in && !slave_req_ff && cfg_ff.pmode == SPCTL_PA_SLAVE &&
			cfg_ff.prio != 2'h0;
	endsequence

	// a later read must still show the pins, whatever was written over bits 6:5
	property p_ro_bits;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		s_ctrl_write ##[1:4] s_ctrl_read |=> rdata_out[6:5] == $past(boot_mode_pins_in);
	endproperty
	a_ro_bits: assert property (p_ro_bits) else $error("written bits leaked");

	property p_cs;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		slave_chip_select_n_out == (cfg_ff.cs_from_pb6 ? port_b_bit_six_in : port_e_bit_seven_in);
	endproperty
	a_cs: assert property (p_cs) else $error("chip select source wrong");

	property p_in_mode;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		cfg_ff.pmode == SPCTL_PA_INPUT |-> !pa_drive_out && !slave_port_en_out;
	endproperty
	a_in_mode: assert property (p_in_mode) else $error("input mode wrong");

	property p_out_mode;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		cfg_ff.pmode == SPCTL_PA_OUTPUT |-> pa_drive_out && !slave_port_en_out && !io_bus_en_out;
	endproperty
	a_out_mode: assert property (p_out_mode) else $error("output mode wrong");

	property p_slave_mode;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		(wr_ctrl && wdata_in[3:2] == 2'b10) |=> slave_port_en_out && !pa_drive_out;
	endproperty
	a_slave_mode: assert property (p_slave_mode) else $error("slave mode wrong");

	property p_bus_mode;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		io_bus_en_out |-> pb_addr_en_out && pa_drive_out && cfg_ff.pmode == SPCTL_PA_IOBUS;
	endproperty
	a_bus_mode: assert property (p_bus_mode) else $error("io bus mode wrong");

	property p_no_irq;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		cfg_ff.prio == 2'h0 |-> irq_prio_out == 2'h0;
	endproperty
	a_no_irq: assert property (p_no_irq) else $error("irq raised when disabled");

	property p_prio;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		(slave_irq_req_in && slave_port_en_out) |-> irq_prio_out == cfg_ff.prio;
	endproperty
	a_prio: assert property (p_prio) else $error("irq priority wrong");

	property p_ctrl_store;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		s_ctrl_write |=>
			{cfg_ff.cs_from_pb6, cfg_ff.pmode, cfg_ff.prio} == $past(wdata_in[4:0]);
	endproperty
	a_ctrl_store: assert property (p_ctrl_store) else $error("fields not stored");

	property p_fetch_hold;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		!wr_ctrl |=> $stable(fetch_by_pins_out);
	endproperty
	a_fetch_hold: assert property (p_fetch_hold) else $error("fetch moved alone");

	property p_slave_excl;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		slave_port_en_out |-> !io_bus_en_out && !pa_drive_out && !pb_addr_en_out;
	endproperty
	a_slave_excl: assert property (p_slave_excl) else $error("slave mode overlap");

	property p_bus_full;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		cfg_ff.pmode == SPCTL_PA_IOBUS |->
			io_bus_en_out && pb_addr_en_out && pa_drive_out && !slave_port_en_out;
	endproperty
	a_bus_full: assert property (p_bus_full) else $error("io bus incomplete");

	property p_prio_gate;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		irq_prio_out != 2'h0 |-> slave_irq_req_in && slave_port_en_out;
	endproperty
	a_prio_gate: assert property (p_prio_gate) else $error("priority without request");

	// set wins: the event must land even when a clear arrives beside it
	property p_slave_event;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		s_slave_event |=> irq_stat_ff[SPCTL_IRQ_SLAVE];
	endproperty
	a_slave_event: assert property (p_slave_event) else $error("slave event lost");

	property p_no_slave_event;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		(cfg_ff.prio == 2'h0 && !irq_stat_ff[SPCTL_IRQ_SLAVE]) |=>
			!irq_stat_ff[SPCTL_IRQ_SLAVE];
	endproperty
	a_no_slave_event: assert property (p_no_slave_event) else $error("event at zero");

	property p_pmchg;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		(wr_ctrl && wdata_in[SPCTL_BIT_PMODE_HI:SPCTL_BIT_PMODE_LO] != cfg_ff.pmode) |=>
			irq_stat_ff[SPCTL_IRQ_PMCHG];
	endproperty
	a_pmchg: assert property (p_pmchg) else $error("mode change not flagged");

	property p_w1c_pmchg;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		(wr_stat && wdata_in[SPCTL_IRQ_PMCHG]) |=> !irq_stat_ff[SPCTL_IRQ_PMCHG];
	endproperty
	a_w1c_pmchg: assert property (p_w1c_pmchg) else $error("mode flag not cleared");

	property p_w1c_slave;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		(wr_stat && wdata_in[SPCTL_IRQ_SLAVE] &&
			!(slave_irq_req_in && !slave_req_ff && irq_prio_out != 2'h0)) |=>
			!irq_stat_ff[SPCTL_IRQ_SLAVE];
	endproperty
	a_w1c_slave: assert property (p_w1c_slave) else $error("slave flag not cleared");

	property p_mask_write;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		(clk_en_in && wr_in && addr_in == SPCTL_ADDR_IRQ_MASK) |=>
			irq_mask_ff == $past(wdata_in[1:0]);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask not stored");

	property p_irq_masked;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		irq_mask_ff == 2'h0 |-> !irq_out;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("masked irq raised");

	property p_irq_pending;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		(irq_stat_ff & irq_mask_ff) != 2'h0 |-> irq_out;
	endproperty
	a_irq_pending: assert property (p_irq_pending) else $error("pending irq not raised");

	property p_rdata_idle;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		(clk_en_in && !rd_in) |=> rdata_out == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outlived its cycle");

	property p_rd_stat;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		(clk_en_in && rd_in && addr_in == SPCTL_ADDR_IRQ_STAT) |=>
			rdata_out == {6'h00, $past(irq_stat_ff)};
	endproperty
	a_rd_stat: assert property (p_rd_stat) else $error("status read wrong");

	property p_rd_mask;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		(clk_en_in && rd_in && addr_in == SPCTL_ADDR_IRQ_MASK) |=>
			rdata_out == {6'h00, $past(irq_mask_ff)};
	endproperty
	a_rd_mask: assert property (p_rd_mask) else $error("mask read wrong");

	property p_rd_other;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		(clk_en_in && rd_in && addr_in != SPCTL_ADDR_CTRL &&
			addr_in != SPCTL_ADDR_IRQ_STAT && addr_in != SPCTL_ADDR_IRQ_MASK) |=>
			rdata_out == 8'h00;
	endproperty
	a_rd_other: assert property (p_rd_other) else $error("unmapped read not zero");

	// a low clock enable must hold every register, including the pending read data
	property p_freeze;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		!clk_en_in |=>
			$stable({cfg_ff, irq_stat_ff, irq_mask_ff, rdata_ff, slave_req_ff});
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen");

	// no reset guard here: this one is about the reset itself
	property p_reset_state;
		@(posedge sys_clk_in)
		!resetn_in |=> fetch_by_pins_out && !slave_port_en_out && !io_bus_en_out &&
			!pa_drive_out && !irq_out && rdata_out == 8'h00;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
endmodule // spctl_top

// ===== hw/spctl_pkg.sv
package spctl_pkg;
	// register map
	localparam logic [7:0] SPCTL_ADDR_CTRL     = 8'h24;
	localparam logic [7:0] SPCTL_ADDR_IRQ_STAT = 8'h25;
	localparam logic [7:0] SPCTL_ADDR_IRQ_MASK = 8'h26;
	// control field positions
	localparam int SPCTL_BIT_FETCH_IGN = 7;
	localparam int SPCTL_BIT_MODE_HI   = 6;
	localparam int SPCTL_BIT_MODE_LO   = 5;
	localparam int SPCTL_BIT_CS_SEL    = 4;
	localparam int SPCTL_BIT_PMODE_HI  = 3;
	localparam int SPCTL_BIT_PMODE_LO  = 2;
	localparam int SPCTL_BIT_PRIO_HI   = 1;
	localparam int SPCTL_BIT_PRIO_LO   = 0;
	// reset values
	localparam logic [7:0] SPCTL_CTRL_RST = 8'h00;
	localparam logic [1:0] SPCTL_IRQ_RST  = 2'h0;
	// interrupt status bits
	localparam int SPCTL_IRQ_SLAVE  = 0;
	localparam int SPCTL_IRQ_PMCHG  = 1;

	typedef enum logic [1:0] {
		SPCTL_PA_INPUT  = 2'b00,
		SPCTL_PA_OUTPUT = 2'b01,
		SPCTL_PA_SLAVE  = 2'b10,
		SPCTL_PA_IOBUS  = 2'b11
	} spctl_pmode_e;

	typedef struct packed {
		logic         fetch_ignore;
		logic         cs_from_pb6;
		spctl_pmode_e pmode;
		logic [1:0]   prio;
	} spctl_cfg_s;

	typedef struct packed {
		logic slave_port_en;
		logic io_bus_en;
		logic pa_drive;
		logic pb_addr_en;
	} spctl_port_s;
endpackage : spctl_pkg

// ===== hw/spctl_decode.sv
module spctl_decode
	import spctl_pkg::*;
(
	// configuration
	input  wire spctl_cfg_s  cfg_in,
	// pins and requests
	input  wire logic        port_e_bit_seven_in,
	input  wire logic        port_b_bit_six_in,
	input  wire logic        slave_irq_req_in,
	// decoded controls
	output spctl_port_s      port_out,
	output logic             slave_chip_select_n_out,
	output logic [1:0]       irq_prio_out
);
	always_comb begin
		port_out = '0;
		case (cfg_in.pmode)
			SPCTL_PA_INPUT: begin
				port_out = '0;
			end
			SPCTL_PA_OUTPUT: begin
				port_out.pa_drive = 1'b1;
			end
			SPCTL_PA_SLAVE: begin
				port_out.slave_port_en = 1'b1;
			end
			SPCTL_PA_IOBUS: begin
				port_out.io_bus_en  = 1'b1;
				port_out.pa_drive   = 1'b1;
				port_out.pb_addr_en = 1'b1;
			end
			default: begin
				port_out = '0;
			end
		endcase
	end

	// chip select only meaningful while the slave port is enabled
	assign slave_chip_select_n_out = cfg_in.cs_from_pb6 ? port_b_bit_six_in
	                                                    : port_e_bit_seven_in;

	// a priority of zero leaves the request silent
	assign irq_prio_out = (slave_irq_req_in && cfg_in.pmode == SPCTL_PA_SLAVE)
	                      ? cfg_in.prio : 2'h0;
endmodule // spctl_decode

// ===== test/spctl_host_model.sv
// far-side host: pulls its chip select low and raises its interrupt request for one frame
module spctl_host_model (
	// clock and reset
	input  wire logic sys_clk_in,
	input  wire logic resetn_in,
	// frame control
	input  wire logic start_in,
	input  wire logic use_pb6_in,
	// pins
	output logic      port_e_bit_seven_out,
	output logic      port_b_bit_six_out,
	output logic      slave_irq_req_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] frame_cnt_ff;
	logic       active;

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			frame_cnt_ff <= 3'h0;
		end else if (start_in) begin
			frame_cnt_ff <= 3'h4;
		end else if (frame_cnt_ff != 3'h0) begin
			frame_cnt_ff <= frame_cnt_ff - 3'h1;
		end
	end

	assign active = (frame_cnt_ff != 3'h0);
	// the unused candidate pin idles high, as its pull-up would leave it
	assign port_e_bit_seven_out = ~(active & ~use_pb6_in);
	assign port_b_bit_six_out   = ~(active & use_pb6_in);
	assign slave_irq_req_out    = active;
endmodule // spctl_host_model

// ===== test/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import spctl_pkg::*;
	logic       sys_clk = 0, resetn = 0, clk_en = 1, wr = 0, rd = 0, start = 0, use_pb6 = 0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic [1:0] pins = 2'h2, prio;
	logic       pe7, pb6, req, fetch, cs_n, sp_en, io_en, pa_drv, pb_en, irq;
	logic [2:0] en_tab[4] = '{3'b000, 3'b000, 3'b100, 3'b011};
	int         mismatches = 0, samples_checked = 0;

	always #25 sys_clk = ~sys_clk;

	spctl_top i_dut (.sys_clk_in(sys_clk), .resetn_in(resetn), .clk_en_in(clk_en),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
		.boot_mode_pins_in(pins), .port_e_bit_seven_in(pe7), .port_b_bit_six_in(pb6),
		.slave_irq_req_in(req), .fetch_by_pins_out(fetch), .slave_chip_select_n_out(cs_n),
		.slave_port_en_out(sp_en), .io_bus_en_out(io_en), .pa_drive_out(pa_drv),
		.pb_addr_en_out(pb_en), .irq_prio_out(prio), .irq_out(irq));
	spctl_host_model i_host (.sys_clk_in(sys_clk), .resetn_in(resetn), .start_in(start),
		.use_pb6_in(use_pb6), .port_e_bit_seven_out(pe7), .port_b_bit_six_out(pb6),
		.slave_irq_req_out(req));

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe, so sample there
	task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 chk(nm, rdata, exp);
	endtask
	task automatic frame(input logic pb);
		@(posedge sys_clk);
		start <= 1'b1;
		use_pb6 <= pb;
		@(posedge sys_clk);
		start <= 1'b0;
		#1;
	endtask
	task automatic print_verdict;
		if (mismatches == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge sys_clk);
		resetn <= 1'b1;
		rchk("ctrl", SPCTL_ADDR_CTRL, 8'h40);
		chk("fetch", fetch, 8'h01);
		chk("enables", {sp_en, io_en, pa_drv, pb_en}, 8'h00);
		@(posedge sys_clk);
		pins <= 2'h1;
		wreg(SPCTL_ADDR_CTRL, 8'hE0);
		#1 chk("fetch", fetch, 8'h00);
		rchk("ctrl", SPCTL_ADDR_CTRL, 8'hA0);
		$display("test reset and fetch done");
		for (int s = 0; s < 4; s++) begin
			wreg(SPCTL_ADDR_CTRL, {3'h0, s[1], 4'h0});
			frame(s[0]);
			chk("cs_n", cs_n, s[1] != s[0]);
			repeat (5) @(posedge sys_clk);
		end
		$display("test chip select done");
		for (int m = 0; m < 4; m++) begin
			wreg(SPCTL_ADDR_CTRL, {4'h0, m[1:0], 2'h0});
			#1 chk("enables", {sp_en, io_en, pb_en}, en_tab[m]);
			chk("pa_drive", pa_drv, m[0]);
		end
		rchk("status", SPCTL_ADDR_IRQ_STAT, 8'h02);
		$display("test port modes done");
		wreg(SPCTL_ADDR_CTRL, 8'h08);
		wreg(SPCTL_ADDR_IRQ_STAT, 8'h03);
		for (int p = 0; p < 4; p++) begin
			// odd levels unmask, so masking is exercised with a pending event
			wreg(SPCTL_ADDR_IRQ_MASK, {7'h0, p[0]});
			wreg(SPCTL_ADDR_CTRL, {6'h02, p[1:0]});
			frame(1'b0);
			chk("prio", prio, p[1:0]);
			repeat (5) @(posedge sys_clk);
			#1 chk("irq", irq, p[0]);
			rchk("status", SPCTL_ADDR_IRQ_STAT, p != 0);
			wreg(SPCTL_ADDR_IRQ_STAT, 8'h01);
			#1 chk("irq clear", irq, 8'h00);
		end
		$display("test interrupts done");
		wreg(8'h30, 8'hFF);
		rchk("unmapped", 8'h30, 8'h00);
		$display("test unmapped done");
		// a write taken while the clock enable is low must be lost
		@(posedge sys_clk);
		clk_en <= 1'b0;
		wreg(SPCTL_ADDR_CTRL, 8'h8F);
		@(posedge sys_clk);
		clk_en <= 1'b1;
		rchk("frozen", SPCTL_ADDR_CTRL, 8'h2B);
		$display("test clock enable done");
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		print_verdict();
	end
endmodule // tb
